// >>> general_purpose_port_zero_tb.sv
`timescale 1ns/1ns
module general_purpose_port_zero_tb;
    import gpz_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'h1;
    logic rmw_read_i = 1'b0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [7:0] pin_i, pin_o, pin_oe_o, pullup_o, digital_in_o, rd;
    logic [7:0] periph_oe_i = 8'h00;
    logic [7:0] periph_out_i = 8'h00;
    logic [7:0] ext_en = 8'hff;
    logic [7:0] ext_val = 8'h3c;
    logic standby_i = 1'b0;
    logic irq_line_five_o, cmp_in_en_o;
    int mismatches = 0;
    int samples_checked = 0;
    always #20 clk_i = ~clk_i;
    gpz_port #(.W(8), .ANALOG_PINS(8'hff)) DUT (.clk_i, .reset_n_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .rmw_read_i, .avs_readdata_o,
        .avs_waitrequest_o, .pin_i, .pin_o, .pin_oe_o, .pullup_o, .periph_oe_i, .periph_out_i,
        .standby_i, .digital_in_o, .irq_line_five_o, .cmp_in_en_o);
    gpz_pads pads (.clk_i, .port_out_i(pin_o), .port_oe_i(pin_oe_o), .pull_on_i(pullup_o),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_i));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns flag %b expected %b", $time, got, exp);
        end
    endtask
    // ends on a rising edge; checks then see the values settled before it
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one avalon transfer from a rising edge, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic rmw);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_writedata_i <= {24'h0, d};
        rmw_read_i <= rmw;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 100);
        if (n >= 100) begin
            mismatches++;
            $display("[FAIL] %0t ns no bus answer", $time);
        end
        rd = avs_readdata_o[7:0];
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        rmw_read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask
    task automatic rdc(input logic [3:0] a, input logic rmw, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, rmw);
        chk8(rd, exp);
    endtask
    task automatic summarize;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 5000);
        mismatches++;
        $display("[FAIL] %0t ns watchdog expired", $time);
        summarize;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        step(2);
        chk8(pin_oe_o, 8'h00);
        chk8(digital_in_o, 8'h00);
        chk1(cmp_in_en_o, 1'b0);
        rdc(GPZ_IDX_DIR, 1'b0, 8'h00);
        rdc(GPZ_IDX_AIDIS, 1'b0, 8'h00);
        wr(GPZ_IDX_AIDIS, 8'hff);
        chk8(digital_in_o, 8'h3c);
        wr(GPZ_IDX_DATA, 8'ha5);
        chk8(pin_oe_o, 8'h00);
        wr(GPZ_IDX_DIR, 8'hf0);
        chk8(pin_oe_o, 8'hf0);
        chk8(pin_o & pin_oe_o, 8'ha0);
        rdc(GPZ_IDX_DATA, 1'b0, 8'hac);
        rdc(GPZ_IDX_DATA, 1'b1, 8'ha5);
        rdc(GPZ_IDX_PINS, 1'b0, 8'hac);
        avs_byteenable_i <= 4'h0;
        wr(GPZ_IDX_DATA, 8'h00);
        avs_byteenable_i <= 4'h1;
        rdc(GPZ_IDX_DATA, 1'b1, 8'ha5);
        wr(4'h7, 8'hff);
        rdc(4'h7, 1'b0, 8'h00);
        wr(GPZ_IDX_PULL, 8'hff);
        chk8(pullup_o, 8'haf);
        ext_en <= 8'hfc;
        periph_oe_i <= 8'h03;
        periph_out_i <= 8'h02;
        step(3);
        chk8(pin_oe_o, 8'hf3);
        chk8(pin_o & 8'h03, 8'h02);
        chk8(pullup_o, 8'hae);
        chk1(irq_line_five_o, 1'b0);
        rdc(GPZ_IDX_DATA, 1'b0, 8'hae);
        rdc(GPZ_IDX_DATA, 1'b1, 8'ha5);
        periph_out_i <= 8'h03;
        step(3);
        chk1(irq_line_five_o, 1'b1);
        periph_oe_i <= 8'h00;
        ext_en <= 8'hff;
        wr(GPZ_IDX_CMP, 8'h00);
        chk1(cmp_in_en_o, 1'b1);
        wr(GPZ_IDX_CMP, 8'h01);
        chk1(cmp_in_en_o, 1'b0);
        wr(GPZ_IDX_STBY, 8'h00);
        standby_i <= 1'b1;
        step(2);
        wr(GPZ_IDX_DATA, 8'h0f);
        wr(GPZ_IDX_DIR, 8'h0f);
        chk8(pin_oe_o, 8'hf0);
        chk8(pin_o & pin_oe_o, 8'ha0);
        standby_i <= 1'b0;
        step(3);
        chk8(pin_oe_o, 8'h0f);
        ext_val <= 8'h3d;
        wr(GPZ_IDX_STBY, 8'h01);
        standby_i <= 1'b1;
        step(3);
        chk8(pin_oe_o, 8'h00);
        chk8(digital_in_o, 8'h00);
        wr(GPZ_IDX_STBY, 8'h03);
        step(2);
        chk8(digital_in_o, 8'h01);
        chk1(irq_line_five_o, 1'b1);
        standby_i <= 1'b0;
        reset_n_i <= 1'b0;
        step(2);
        chk8(pin_oe_o, 8'h00);
        reset_n_i <= 1'b1;
        step(1);
        rdc(GPZ_IDX_DIR, 1'b0, 8'h00);
        rdc(GPZ_IDX_AIDIS, 1'b0, 8'h00);
        wr(GPZ_IDX_PULL, 8'h00);
        chk8(digital_in_o, 8'h00);
        rdc(GPZ_IDX_DATA, 1'b0, 8'h3d);
        rdc(GPZ_IDX_DATA, 1'b1, 8'h00);
        summarize;
    end
endmodule

// >>> gpz_pads.sv
`timescale 1ns/1ns
module gpz_pads (
    input wire logic clk_i, // clock
    input wire logic [7:0] port_out_i, // port drive level
    input wire logic [7:0] port_oe_i, // port drive enable
    input wire logic [7:0] pull_on_i, // pull-up connect
    input wire logic [7:0] ext_en_i, // outside driver enable
    input wire logic [7:0] ext_val_i, // outside driver level
    output logic [7:0] level_o // resolved pad level
);
    logic [7:0] float_reg = 8'h55;
    // undriven pads wander so a stale level never passes
    always @(posedge clk_i) begin
        float_reg <= ~level_o;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (port_oe_i[i]) begin
                level_o[i] = port_out_i[i];
            end else if (ext_en_i[i]) begin
                level_o[i] = ext_val_i[i];
            end else if (pull_on_i[i]) begin
                level_o[i] = 1'b1;
            end else begin
                level_o[i] = float_reg[i];
            end
        end
    end
endmodule

// >>> gpz_pkg.sv
package gpz_pkg;
    localparam int GPZ_WIDTH = 8;
    // register indices (word addresses)
    localparam logic [3:0] GPZ_IDX_DATA = 4'h0;
    localparam logic [3:0] GPZ_IDX_DIR = 4'h1;
    localparam logic [3:0] GPZ_IDX_PULL = 4'h2;
    localparam logic [3:0] GPZ_IDX_AIDIS = 4'h3;
    localparam logic [3:0] GPZ_IDX_STBY = 4'h4;
    localparam logic [3:0] GPZ_IDX_CMP = 4'h5;
    localparam logic [3:0] GPZ_IDX_PINS = 4'h6;
    localparam int GPZ_BIT_SPL = 0;
    localparam int GPZ_BIT_COMPARATOR_INPUT_ENABLE_N = 0;
    localparam int GPZ_BIT_IRQEN = 0;
    localparam logic [7:0] GPZ_RST_DATA = 8'h00;
    localparam logic [7:0] GPZ_RST_DIR = 8'h00;
    localparam logic [7:0] GPZ_RST_PULL = 8'h00;
    localparam logic [7:0] GPZ_RST_AIDIS = 8'h00;
    localparam logic [31:0] GPZ_UNMAPPED = 32'h00000000;

    typedef enum logic [2:0] {
        GPZ_IDLE = 3'b001,
        GPZ_RESP = 3'b010,
        GPZ_DONE = 3'b100
    } gpz_bus_state_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } gpz_pad_t;
endpackage

// >>> gpz_port.sv
// Notes on behaviour
// - direction bit one makes the pin a port output.
// - data writes store in the latch; output pins drive it at once; here the pad register drives it one clock after the latch updates.
// - output pins read back the latch.
// - direction bit zero makes the pin a port input.
// - latch still updates for input pins but is not driven.
// - input pins read the pin level; read-modify-write reads get the latch.
// - peripheral output enable hands the pin to the peripheral.
// - peripheral-driven pins read the pin level; read-modify-write gets latch.
// - peripheral-input pins read the pin level; read-modify-write gets latch.
// - reset clears direction and analog disable registers.
// - standby with select one floats pins, blocks inputs unless irq enabled; here irq enable lets only the interrupt pin through, the rest stay blocked.
// - standby with select zero keeps pin states and levels.
// - pin level always feeds the external interrupt circuit; here the irq line is held low in standby with select one and irq disabled.
// - pull-up bit connects pull-up, removed while the pin drives low.
// - comparator input enabled when enable bit is zero, else disabled.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
module gpz_port
    import gpz_pkg::*;
#(
    parameter int W = GPZ_WIDTH,
    parameter logic [W-1:0] ANALOG_PINS = 8'hff
) (
    input wire logic clk_i, // 25 MHz clock
    input wire logic reset_n_i, // async reset, active low
    input wire logic [3:0] avs_address_i, // word index
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [31:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte enables
    input wire logic rmw_read_i, // read-modify-write qualifier
    output logic [31:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // stall
    input wire logic [W-1:0] pin_i, // pad input level
    output logic [W-1:0] pin_o, // pad output level
    output logic [W-1:0] pin_oe_o, // pad output enable
    output logic [W-1:0] pullup_o, // pull-up connect
    input wire logic [W-1:0] periph_oe_i, // peripheral output enables
    input wire logic [W-1:0] periph_out_i, // peripheral output data
    input wire logic standby_i, // stop or watch mode
    output logic [W-1:0] digital_in_o, // gated digital input
    output logic irq_line_five_o, // pin level to external irq
    output logic cmp_in_en_o // comparator input enable
);
    gpz_bus_state_t st_reg, st_next;
    logic [31:0] rd_reg, rd_next;
    logic [W-1:0] data_q, dir_q, pull_q, aid_q;
    logic spl_q, comparator_input_enable_n_q, irqen_q, wr_en;
    logic wait_reg, wait_next;
    gpz_pad_t pad_reg, pad_next;
    logic [W-1:0] din_reg, din_next;
    logic irq_reg, irq_next, cmp_reg, cmp_next;

    ////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, answer in the second
    assign wr_en = (st_reg == GPZ_IDLE) && avs_write_i && avs_byteenable_i[0];

    function automatic logic [W-1:0] data_view(input logic [W-1:0] lat,
            input logic [W-1:0] dir, input logic [W-1:0] poe,
            input logic [W-1:0] lvl, input logic rmw);
        // port outputs read latch; input and peripheral pins read level
        if (rmw) begin
            data_view = lat;
        end else begin
            data_view = (dir & ~poe & lat) | ~(dir & ~poe) & lvl;
        end
    endfunction

    always_comb begin
        st_next = st_reg;
        rd_next = rd_reg;
        unique case (st_reg)
            GPZ_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    st_next = GPZ_RESP;
                    rd_next = GPZ_UNMAPPED;
                    if (avs_read_i) begin
                        unique case (avs_address_i)
                            GPZ_IDX_DATA: rd_next[W-1:0] = data_view(data_q, dir_q,
                                periph_oe_i, pin_i, rmw_read_i);
                            GPZ_IDX_DIR: rd_next[W-1:0] = dir_q;
                            GPZ_IDX_PULL: rd_next[W-1:0] = pull_q;
                            GPZ_IDX_AIDIS: rd_next[W-1:0] = aid_q;
                            GPZ_IDX_STBY: rd_next[1:0] = {irqen_q, spl_q};
                            GPZ_IDX_CMP: rd_next[GPZ_BIT_COMPARATOR_INPUT_ENABLE_N] = comparator_input_enable_n_q;
                            GPZ_IDX_PINS: rd_next[W-1:0] = pin_i;
                            default: ;
                        endcase
                    end
                end
            end
            GPZ_RESP: st_next = GPZ_DONE;
            GPZ_DONE: st_next = GPZ_IDLE;
            default: st_next = GPZ_IDLE;
        endcase
        // registered so the stall output comes straight from a flop
        wait_next = (st_next != GPZ_RESP);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= GPZ_IDLE;
            rd_reg <= GPZ_UNMAPPED;
            wait_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            rd_reg <= rd_next;
            wait_reg <= wait_next;
        end
    end

    assign avs_waitrequest_o = wait_reg;
    assign avs_readdata_o = rd_reg;

    gpz_regfile #(.W(W)) u_regs (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .we_i(wr_en),
        .idx_i(avs_address_i),
        .wdata_i(avs_writedata_i[W-1:0]),
        .data_o(data_q),
        .dir_o(dir_q),
        .pull_o(pull_q),
        .aidis_o(aid_q),
        .spl_o(spl_q),
        .comparator_input_enable_n_o(comparator_input_enable_n_q),
        .irqen_o(irqen_q)
    );

    ////////////////////////////////////////////////////////////////////
    // pad control
    logic float_all;
    assign float_all = standby_i && spl_q;

    always_comb begin
        pad_next = pad_reg;
        din_next = din_reg;
        if (!standby_i) begin
            for (int i = 0; i < W; i++) begin
                pad_next.oe[i] = periph_oe_i[i] | dir_q[i];
                pad_next.out[i] = periph_oe_i[i] ? periph_out_i[i] : data_q[i];
            end
            din_next = pin_i & (~ANALOG_PINS | aid_q);
        end else if (float_all) begin
            pad_next.oe = '0;
            // only the interrupt pin stays open, and only with irq enabled; the rest read low
            din_next = '0;
            din_next[GPZ_BIT_IRQEN] = irqen_q && pin_i[GPZ_BIT_IRQEN];
        end else begin
            din_next = pin_i & (~ANALOG_PINS | aid_q);
        end
        pad_next.pull = pull_q & ~(pad_next.oe & ~pad_next.out);
    end

    always_comb begin
        irq_next = pin_i[GPZ_BIT_IRQEN];
        if (float_all && !irqen_q) begin
            irq_next = 1'b0;
        end
        cmp_next = ~comparator_input_enable_n_q;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pad_reg <= '0;
            din_reg <= '0;
            irq_reg <= 1'b0;
            cmp_reg <= 1'b0;
        end else begin
            pad_reg <= pad_next;
            din_reg <= din_next;
            irq_reg <= irq_next;
            cmp_reg <= cmp_next;
        end
    end

    assign pin_o = pad_reg.out;
    assign pin_oe_o = pad_reg.oe;
    assign pullup_o = pad_reg.pull;
    assign digital_in_o = din_reg;
    assign irq_line_five_o = irq_reg;
    assign cmp_in_en_o = cmp_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    logic [W-1:0] own_mask, drive_want;
    // pins that the port itself drives, and pins that anyone drives
    assign own_mask = dir_q & ~periph_oe_i;
    assign drive_want = dir_q | periph_oe_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_out_drive: assert property (!standby_i && dir_q[0] && !periph_oe_i[0] |=>
        pin_oe_o[0] && pin_o[0] == $past(data_q[0])) else $error("output pin not driven");
    a_in_float: assert property (!standby_i && !dir_q[0] && !periph_oe_i[0] |=>
        !pin_oe_o[0]) else $error("input pin driven");
    a_periph_own: assert property (!standby_i && periph_oe_i[1] |=>
        pin_o[1] == $past(periph_out_i[1])) else $error("peripheral not on pin");
    a_rmw_latch: assert property (st_reg == GPZ_IDLE && avs_read_i && rmw_read_i
        && avs_address_i == GPZ_IDX_DATA |=> avs_readdata_o[W-1:0] == $past(data_q))
        else $error("rmw read not latch");
    a_in_level: assert property (st_reg == GPZ_IDLE && avs_read_i && !rmw_read_i
        && avs_address_i == GPZ_IDX_DATA && dir_q == '0 |=>
        avs_readdata_o[W-1:0] == $past(pin_i)) else $error("input read not level");
    a_stby_float: assert property (standby_i && spl_q |=> pin_oe_o == '0)
        else $error("pins driven in standby");
    a_stby_hold: assert property (standby_i && !spl_q |=> $stable(pin_oe_o))
        else $error("pins changed in standby");
    a_pull_low: assert property (pin_oe_o[2] && !pin_o[2] |-> !pullup_o[2])
        else $error("pull-up on low pin");
    a_cmp_en: assert property (##1 cmp_in_en_o == !$past(comparator_input_enable_n_q))
        else $error("comparator enable wrong");
    a_bus_ack: assert property (st_reg == GPZ_IDLE && avs_write_i |=> !avs_waitrequest_o)
        else $error("no answer");
    a_wait_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low twice");
    a_rd_unmapped: assert property (st_reg == GPZ_IDLE && avs_read_i
        && avs_address_i > GPZ_IDX_PINS |=> avs_readdata_o == GPZ_UNMAPPED)
        else $error("unmapped read not zero");
    a_rd_upper: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:W] == '0)
        else $error("upper read bits set");
    a_latch_write: assert property (wr_en && avs_address_i == GPZ_IDX_DATA |=>
        data_q == $past(avs_writedata_i[W-1:0])) else $error("latch not written");
    a_out_read: assert property (st_reg == GPZ_IDLE && avs_read_i && !rmw_read_i
        && avs_address_i == GPZ_IDX_DATA |=> (avs_readdata_o[W-1:0] & $past(own_mask))
        == ($past(data_q) & $past(own_mask))) else $error("output read not latch");
    a_pin_read: assert property (st_reg == GPZ_IDLE && avs_read_i && !rmw_read_i
        && avs_address_i == GPZ_IDX_DATA |=> (avs_readdata_o[W-1:0] & ~$past(own_mask))
        == ($past(pin_i) & ~$past(own_mask))) else $error("pin read not level");
    a_irq_feed: assert property (!(float_all && !irqen_q) |=>
        irq_line_five_o == $past(pin_i[GPZ_BIT_IRQEN])) else $error("irq line not pin");
    a_pull_high: assert property (!(pin_oe_o[4] && !pin_o[4]) |->
        pullup_o[4] == $past(pull_q[4])) else $error("pull-up not connected");
    a_stby_block: assert property (standby_i && spl_q && !irqen_q |=>
        digital_in_o == '0) else $error("input not blocked");
    a_stby_out: assert property (standby_i && !spl_q |=> $stable(pin_o))
        else $error("pin level changed in standby");

    for (genvar g = 0; g < W; g++) begin : g_pin
        a_pin_dir: assert property (!standby_i |=>
            pin_oe_o[g] == $past(drive_want[g])) else $error("pin direction wrong");
    end

    c_write: cover property (wr_en && avs_address_i == GPZ_IDX_DATA);
    c_rmw: cover property (avs_read_i && rmw_read_i && !avs_waitrequest_o);
    c_standby: cover property (standby_i && spl_q);
    c_periph: cover property (periph_oe_i != '0);
    c_float_irq: cover property (standby_i && spl_q && irqen_q);
endmodule

// >>> gpz_regfile.sv
`timescale 1ns/1ns
module gpz_regfile
    import gpz_pkg::*;
#(
    parameter int W = GPZ_WIDTH
) (
    input wire logic clk_i, // clock
    input wire logic reset_n_i, // async reset
    input wire logic we_i, // write strobe
    input wire logic [3:0] idx_i, // register index
    input wire logic [W-1:0] wdata_i, // write data
    output logic [W-1:0] data_o, // data latch
    output logic [W-1:0] dir_o, // direction
    output logic [W-1:0] pull_o, // pull-up enables
    output logic [W-1:0] aidis_o, // analog input disable
    output logic spl_o, // standby pin state select
    output logic comparator_input_enable_n_o, // comparator input enable, low active
    output logic irqen_o // external interrupt enable
);
    logic [W-1:0] data_reg, data_next, dir_reg, dir_next;
    logic [W-1:0] pull_reg, pull_next, aid_reg, aid_next;
    logic spl_reg, spl_next, comparator_input_enable_n_reg, comparator_input_enable_n_next, irq_reg, irq_next;

    always_comb begin
        data_next = data_reg;
        dir_next = dir_reg;
        pull_next = pull_reg;
        aid_next = aid_reg;
        spl_next = spl_reg;
        comparator_input_enable_n_next = comparator_input_enable_n_reg;
        irq_next = irq_reg;
        if (we_i) begin
            unique case (idx_i)
                GPZ_IDX_DATA: data_next = wdata_i;
                GPZ_IDX_DIR: dir_next = wdata_i;
                GPZ_IDX_PULL: pull_next = wdata_i;
                GPZ_IDX_AIDIS: aid_next = wdata_i;
                GPZ_IDX_STBY: begin
                    spl_next = wdata_i[GPZ_BIT_SPL];
                    irq_next = wdata_i[GPZ_BIT_IRQEN + 1];
                end
                GPZ_IDX_CMP: comparator_input_enable_n_next = wdata_i[GPZ_BIT_COMPARATOR_INPUT_ENABLE_N];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_reg <= GPZ_RST_DATA;
            dir_reg <= GPZ_RST_DIR;
            pull_reg <= GPZ_RST_PULL;
            aid_reg <= GPZ_RST_AIDIS;
            spl_reg <= 1'b0;
            comparator_input_enable_n_reg <= 1'b1;
            irq_reg <= 1'b0;
        end else begin
            data_reg <= data_next;
            dir_reg <= dir_next;
            pull_reg <= pull_next;
            aid_reg <= aid_next;
            spl_reg <= spl_next;
            comparator_input_enable_n_reg <= comparator_input_enable_n_next;
            irq_reg <= irq_next;
        end
    end

    assign data_o = data_reg;
    assign dir_o = dir_reg;
    assign pull_o = pull_reg;
    assign aidis_o = aid_reg;
    assign spl_o = spl_reg;
    assign comparator_input_enable_n_o = comparator_input_enable_n_reg;
    assign irqen_o = irq_reg;
endmodule
